// [verilog/sca_ctrl.sv]
// Purpose: APB register bank and switch control for four type-A units
// Assumes: phase inputs synchronous to pclk; zero-wait APB answer
// Notes: units 0..3 each drive a separate column comparator bus
//
// Summary of operation
// - with column bus drive at 0 the column bus switch stays open.
// - with drive set and no phase swap the column bus is driven only late in phase two.
// - with drive set and phase swap set the column bus is driven continuously.
// - bit 6 of cfg2 gates the latched comparator result onto the comparator bus.
// - an undriven comparator bus reads low.
// - the comparator is sampled on rising internal phase one and held through phase two.
// - with offset-null at 0 the short switch is open and both branches go to the amp.
// - with offset-null at 1 the short switch closes in phase one, branches grounded then.
// - the feedback switch is open at 0, else always closed or only in phase two with null.
// - cfg2 bits 4:0 give an unsigned count of 0 to 31 unit capacitors.
// - cfg2 is read/write, resets to zero, fields drive, comparator, null and size.
// - cfg2 of the four units sits at 82h, 8Ah, 96h and 9Eh.
// - cfg1 of the four units sits at 81h, 89h, 95h and 9Dh.
`timescale 1ns/100ps
`default_nettype none
module sca_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sca_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic phase_one,
	input wire logic phase_two,
	input wire logic [sca_pkg::NUM_UNITS-1:0] cmp_result,
	output logic [sca_pkg::NUM_UNITS-1:0] column_bus_drive_en,
	output logic [sca_pkg::NUM_UNITS-1:0] cmp_bus,
	output logic [sca_pkg::NUM_UNITS-1:0] offset_short_sw,
	output logic [sca_pkg::NUM_UNITS-1:0] branch_to_gnd,
	output logic [sca_pkg::NUM_UNITS-1:0] branch_to_amp,
	output logic [sca_pkg::NUM_UNITS-1:0] integ_feedback_switch,
	output logic [sca_pkg::NUM_UNITS*sca_pkg::CAP_UNITS-1:0] c_branch_cap_units
);
	typedef struct packed {
		logic [3:0][7:0] cfg0;
		logic [3:0][7:0] cfg1;
		logic [3:0][7:0] cfg2;
		logic [3:0][7:0] cfg3;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sca_ctrl_state_t;

	sca_ctrl_state_t s;
	sca_ctrl_state_t next_s;
	logic [sca_pkg::NUM_UNITS-1:0] stat_cmp;
	logic [sca_pkg::NUM_UNITS-1:0] stat_col;

	sca_unit_if uif[sca_pkg::NUM_UNITS] ();

	genvar g;
	generate
		for (g = 0; g < sca_pkg::NUM_UNITS; g++) begin : g_unit
			assign uif[g].cfg0 = s.cfg0[g];
			assign uif[g].cfg2 = s.cfg2[g];
			assign uif[g].cfg3 = s.cfg3[g];
			assign uif[g].cmp_result = cmp_result[g];
			sca_unit u_unit (
				.pclk(pclk),
				.presetn(presetn),
				.phase_one(phase_one),
				.phase_two(phase_two),
				.u(uif[g])
			);
			assign column_bus_drive_en[g] = uif[g].col_drive;
			assign cmp_bus[g] = uif[g].cmp_bus;
			assign offset_short_sw[g] = uif[g].short_sw;
			assign branch_to_gnd[g] = uif[g].br_gnd;
			assign branch_to_amp[g] = uif[g].br_amp;
			assign integ_feedback_switch[g] = uif[g].fb_sw;
			assign c_branch_cap_units[g*sca_pkg::CAP_UNITS +: sca_pkg::CAP_UNITS] =
				uif[g].cap_units;
			assign stat_cmp[g] = uif[g].cmp_latched;
			assign stat_col[g] = uif[g].col_drive;
		end
	endgenerate

	always_comb begin
		logic [sca_pkg::ADDR_W-3:0] sel;
		logic hit;
		logic [31:0] rdata;
		logic wr;
		sel = paddr[sca_pkg::ADDR_W-1:2];
		hit = 1'b0;
		rdata = 32'h0000_0000;
		wr = 1'b0;
		next_s = s;
		// register map decode
		for (int i = 0; i < sca_pkg::NUM_UNITS; i++) begin
			if (sel == {2'b00, sca_pkg::IDX_CFG0[i]}) begin
				hit = 1'b1;
				rdata = {24'h00_0000, s.cfg0[i]};
			end
			if (sel == {2'b00, sca_pkg::IDX_CFG1[i]}) begin
				hit = 1'b1;
				rdata = {24'h00_0000, s.cfg1[i]};
			end
			if (sel == {2'b00, sca_pkg::IDX_CFG2[i]}) begin
				hit = 1'b1;
				rdata = {24'h00_0000, s.cfg2[i]};
			end
			if (sel == {2'b00, sca_pkg::IDX_CFG3[i]}) begin
				hit = 1'b1;
				rdata = {24'h00_0000, s.cfg3[i]};
			end
		end
		if (sel == {2'b00, sca_pkg::IDX_STATUS}) begin
			hit = 1'b1;
			rdata = 32'h0000_0000;
			rdata[sca_pkg::STAT_CMP_LSB +: sca_pkg::NUM_UNITS] = stat_cmp;
			rdata[sca_pkg::STAT_COL_LSB +: sca_pkg::NUM_UNITS] = stat_col;
		end
		// answer one cycle after setup, zero wait in access
		next_s.pready = psel & ~penable;
		// error flag stands only with pready
		next_s.pslverr = 1'b0;
		if (psel & ~penable) begin
			next_s.prdata = pwrite ? 32'h0000_0000 : rdata;
			next_s.pslverr = ~hit;
		end
		// write lands at the accepting edge
		wr = psel & penable & s.pready & pwrite & pstrb[0];
		if (wr) begin
			for (int i = 0; i < sca_pkg::NUM_UNITS; i++) begin
				if (sel == {2'b00, sca_pkg::IDX_CFG0[i]}) begin
					next_s.cfg0[i] = pwdata[7:0];
				end
				if (sel == {2'b00, sca_pkg::IDX_CFG1[i]}) begin
					next_s.cfg1[i] = pwdata[7:0];
				end
				if (sel == {2'b00, sca_pkg::IDX_CFG2[i]}) begin
					next_s.cfg2[i] = pwdata[7:0];
				end
				if (sel == {2'b00, sca_pkg::IDX_CFG3[i]}) begin
					next_s.cfg3[i] = pwdata[7:0];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s.cfg0 <= {4{sca_pkg::CFG_RESET}};
			s.cfg1 <= {4{sca_pkg::CFG_RESET}};
			s.cfg2 <= {4{sca_pkg::CFG_RESET}};
			s.cfg3 <= {4{sca_pkg::CFG_RESET}};
			s.prdata <= 32'h0000_0000;
			s.pready <= 1'b0;
			s.pslverr <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
endmodule : sca_ctrl
`default_nettype wire

// [verilog/sca_pkg.sv]
// Purpose: shared constants for the switched-capacitor type-A control block
// Assumes: 32-bit APB, one register per aligned word, byte address = 4 x index
// Notes: index values are the printed register offsets
package sca_pkg;
	localparam int NUM_UNITS = 4;
	localparam int ADDR_W = 12;
	localparam int CAP_UNITS = 31;
	localparam int CNT_W = 8;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// register indexes per unit, unit 0 in the lowest byte
	localparam logic [3:0][7:0] IDX_CFG0 = {8'h9c, 8'h94, 8'h88, 8'h80};
	localparam logic [3:0][7:0] IDX_CFG1 = {8'h9d, 8'h95, 8'h89, 8'h81};
	localparam logic [3:0][7:0] IDX_CFG2 = {8'h9e, 8'h96, 8'h8a, 8'h82};
	localparam logic [3:0][7:0] IDX_CFG3 = {8'h9f, 8'h97, 8'h8b, 8'h83};
	localparam logic [7:0] IDX_STATUS = 8'ha0;
	// cfg2 fields
	localparam int COL_DRIVE_BIT = 7;
	localparam int CMP_DRIVE_BIT = 6;
	localparam int NULL_BIT = 5;
	localparam int CAP_MSB = 4;
	localparam int CAP_LSB = 0;
	// cfg0 and cfg3 fields
	localparam int PHASE_SWAP_BIT = 6;
	localparam int FB_SW_BIT = 5;
	// status fields
	localparam int STAT_CMP_LSB = 0;
	localparam int STAT_COL_LSB = 4;
endpackage : sca_pkg

// [verilog/sca_unit_if.sv]
// Purpose: carries configuration and switch enables between control and one unit
// Assumes: single pclk domain
// Notes: none
`timescale 1ns/100ps
`default_nettype none
interface sca_unit_if;
	logic [7:0] cfg0;
	logic [7:0] cfg2;
	logic [7:0] cfg3;
	logic cmp_result;
	logic col_drive;
	logic cmp_bus;
	logic cmp_latched;
	logic short_sw;
	logic br_gnd;
	logic br_amp;
	logic fb_sw;
	logic [sca_pkg::CAP_UNITS-1:0] cap_units;
	modport ctrl (
		output cfg0,
		output cfg2,
		output cfg3,
		output cmp_result,
		input col_drive,
		input cmp_bus,
		input cmp_latched,
		input short_sw,
		input br_gnd,
		input br_amp,
		input fb_sw,
		input cap_units
	);
	modport unit (
		input cfg0,
		input cfg2,
		input cfg3,
		input cmp_result,
		output col_drive,
		output cmp_bus,
		output cmp_latched,
		output short_sw,
		output br_gnd,
		output br_amp,
		output fb_sw,
		output cap_units
	);
endinterface : sca_unit_if
`default_nettype wire

// [verilog/sca_unit.sv]
// Purpose: switch phasing for one switched-capacitor type-A unit
// Assumes: phase inputs synchronous to pclk and non-overlapping
// Notes: configuration is taken over at each rising internal phase edge
`timescale 1ns/100ps
`default_nettype none
module sca_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic phase_one,
	input wire logic phase_two,
	sca_unit_if.unit u
);
	typedef struct packed {
		logic p1_d;
		logic p2_d;
		logic [7:0] act_cfg2;
		logic act_swap;
		logic act_fb;
		logic [sca_pkg::CNT_W-1:0] p2_cnt;
		logic [sca_pkg::CNT_W-1:0] p2_len;
		logic cmp_latch;
		logic col_drive;
		logic cmp_bus;
		logic short_sw;
		logic br_gnd;
		logic br_amp;
		logic fb_sw;
		logic [sca_pkg::CAP_UNITS-1:0] cap_units;
	} sca_unit_state_t;

	sca_unit_state_t s;
	sca_unit_state_t next_s;

	always_comb begin
		logic ip1;
		logic ip2;
		logic late;
		logic col_en;
		logic nul;
		ip1 = 1'b0;
		ip2 = 1'b0;
		late = 1'b0;
		col_en = 1'b0;
		nul = 1'b0;
		next_s = s;
		// swapped phasing exchanges the internal phases
		ip1 = s.act_swap ? phase_two : phase_one;
		ip2 = s.act_swap ? phase_one : phase_two;
		next_s.p1_d = ip1;
		next_s.p2_d = ip2;
		// new settings take effect only at a phase edge
		if ((ip1 & ~s.p1_d) | (ip2 & ~s.p2_d)) begin
			next_s.act_cfg2 = u.cfg2;
			next_s.act_swap = u.cfg0[sca_pkg::PHASE_SWAP_BIT];
			next_s.act_fb = u.cfg3[sca_pkg::FB_SW_BIT];
		end
		// phase two length, measured to find its final portion
		if (ip2 & ~s.p2_d) begin
			next_s.p2_cnt = '0;
		end else if (ip2 && s.p2_cnt != {sca_pkg::CNT_W{1'b1}}) begin
			next_s.p2_cnt = s.p2_cnt + 1'b1;
		end
		if (~ip2 & s.p2_d) begin
			next_s.p2_len = s.p2_cnt;
		end
		// rising cycle skipped, its count is left from the last phase two
		late = ip2 & s.p2_d & (s.p2_cnt >= (s.p2_len >> 1));
		col_en = s.act_cfg2[sca_pkg::COL_DRIVE_BIT];
		nul = s.act_cfg2[sca_pkg::NULL_BIT];
		// bus switch open when disabled
		// late phase two only
		// continuous when swapped
		next_s.col_drive = col_en & (s.act_swap | late);
		// latch comparator on rising internal phase one
		if (ip1 & ~s.p1_d) begin
			next_s.cmp_latch = u.cmp_result;
		end
		// comparator bus enable, low when not driven
		next_s.cmp_bus = s.act_cfg2[sca_pkg::CMP_DRIVE_BIT] & next_s.cmp_latch;
		// offset nulling switches
		next_s.short_sw = nul & ip1;
		next_s.br_gnd = nul & ip1;
		next_s.br_amp = ~nul | ip2;
		// integrator feedback switch
		next_s.fb_sw = s.act_fb & (~nul | ip2);
		// unit capacitors enabled by binary count
		for (int i = 0; i < sca_pkg::CAP_UNITS; i++) begin
			next_s.cap_units[i] = (i < int'(s.act_cfg2[sca_pkg::CAP_MSB:sca_pkg::CAP_LSB]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign u.col_drive = s.col_drive;
	assign u.cmp_bus = s.cmp_bus;
	assign u.cmp_latched = s.cmp_latch;
	assign u.short_sw = s.short_sw;
	assign u.br_gnd = s.br_gnd;
	assign u.br_amp = s.br_amp;
	assign u.fb_sw = s.fb_sw;
	assign u.cap_units = s.cap_units;
endmodule : sca_unit
`default_nettype wire

// [test/sca_checker.sv]
// Purpose: port checks for sca_ctrl
// Assumes: one pclk domain
// Notes: bound below
`timescale 1ns/100ps
`default_nettype none
module sca_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] offset_short_sw,
	input wire logic [3:0] branch_to_gnd,
	input wire logic [3:0] branch_to_amp,
	input wire logic [3:0] integ_feedback_switch,
	input wire logic [123:0] c_branch_cap_units
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_short_gnd: assert property (offset_short_sw == branch_to_gnd)
		else $error("short and ground differ");
	a_amp_gnd: assert property ((branch_to_amp & branch_to_gnd) == 4'h0)
		else $error("amp and ground both on");
	a_fb_short: assert property ((integ_feedback_switch & offset_short_sw) == 4'h0)
		else $error("feedback and short both on");
	a_cap_thermo: assert property (((c_branch_cap_units[30:0] + 31'h0000_0001)
		& c_branch_cap_units[30:0]) == 31'h0000_0000) else $error("cap not a count");
	a_zero_wait: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready too long");
	a_err_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("bad error answer");
	a_rd_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
endmodule : sca_checker
bind sca_ctrl sca_checker sca_checker_i (.pclk, .presetn, .psel, .penable, .prdata, .pready,
	.pslverr, .offset_short_sw, .branch_to_gnd, .branch_to_amp, .integ_feedback_switch,
	.c_branch_cap_units);
`default_nettype wire

// [test/sca_far_side.sv]
// Purpose: phase clocks and comparator levels
// Assumes: ten cycle period
// Notes: gap cycle between phases
`timescale 1ns/100ps
`default_nettype none
module sca_far_side (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cmp_level,
	output logic phase_one,
	output logic phase_two,
	output logic [3:0] cmp_result,
	output logic [3:0] step
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step <= 4'h0;
		end else begin
			step <= (step == 4'h9) ? 4'h0 : step + 4'h1;
		end
	end
	// non-overlapping phases
	assign phase_one = presetn && step <= 4'h3;
	assign phase_two = step >= 4'h5 && step <= 4'h8;
	assign cmp_result = {4{cmp_level}};
endmodule : sca_far_side
`default_nettype wire

// [test/sca_ctrl_test.sv]
// Purpose: register and switch tests
// Assumes: phases from sca_far_side
// Notes: unit 0 takes switch tests
`timescale 1ns/100ps
`default_nettype none
module sca_ctrl_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic cmp_level = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, er, phase_one, phase_two;
	logic [31:0] prdata, rd;
	logic [3:0] cmp_result, step, col, cmp_bus, sh, gnd, amp, fb, sw;
	logic [123:0] cap;
	logic [7:0] a1 [4] = '{8'h81, 8'h89, 8'h95, 8'h9d};
	logic [7:0] a2 [4] = '{8'h82, 8'h8a, 8'h96, 8'h9e};
	int num_errors = 0;
	int n_tests = 0;
	assign sw = {sh[0], gnd[0], amp[0], fb[0]};
	always #5 pclk = ~pclk;
	sca_ctrl sca_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .phase_one, .phase_two, .cmp_result,
		.column_bus_drive_en(col), .cmp_bus, .offset_short_sw(sh), .branch_to_gnd(gnd),
		.branch_to_amp(amp), .integ_feedback_switch(fb), .c_branch_cap_units(cap));
	sca_far_side sca_far_side_i (.pclk, .presetn, .cmp_level, .phase_one, .phase_two,
		.cmp_result, .step);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	task automatic limit(input logic ok);
		if (!ok) begin
			num_errors++;
			print_verdict();
		end
	endtask : limit
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		int k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h00_0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 8);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		limit(pready === 1'b1);
	endtask : xfer
	task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(nm, rd, {24'h00_0000, exp});
	endtask : rd_chk
	task automatic at(input logic [3:0] k);
		int j = 0;
		do begin
			@(posedge pclk);
			j++;
		end while (step !== k && j < 20);
		limit(step === k);
	endtask : at
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int u = 0; u < 4; u++) begin
			rd_chk("cfg2 reset", a2[u], 8'h00);
			xfer(1'b1, a1[u], 8'h11 << u);
			xfer(1'b1, a2[u], 8'hc1 + 8'(u));
		end
		for (int u = 0; u < 4; u++) begin
			rd_chk("cfg1", a1[u], 8'h11 << u);
			rd_chk("cfg2", a2[u], 8'hc1 + 8'(u));
		end
		xfer(1'b0, 8'h10, 8'h00);
		chk("unmapped", 32'(er), 32'(1'b1));
		// null off, feedback on
		xfer(1'b1, a2[0], 8'h00);
		xfer(1'b1, sca_pkg::IDX_CFG3[0], 8'h20);
		repeat (2) at(4'h0);
		chk("col off", 32'(col[0]), 32'(1'b0));
		chk("sw no null", 32'(sw), 32'(4'h3));
		// null on, size 5
		cmp_level <= 1'b1;
		xfer(1'b1, a2[0], 8'he5);
		repeat (2) at(4'h0);
		at(4'h3);
		chk("col p1", 32'(col[0]), 32'(1'b0));
		chk("sw p1", 32'(sw), 32'(4'hc));
		at(4'h6);
		chk("col early p2", 32'(col[0]), 32'(1'b0));
		cmp_level <= 1'b0;
		at(4'h8);
		chk("col late p2", 32'(col[0]), 32'(1'b1));
		chk("sw p2", 32'(sw), 32'(4'h3));
		chk("cmp held", 32'(cmp_bus[0]), 32'(1'b1));
		chk("cap 5", {1'b0, cap[30:0]}, 32'h0000_001f);
		at(4'h3);
		chk("cmp new", 32'(cmp_bus[0]), 32'(1'b0));
		// comparator drive off on unit 0 only
		cmp_level <= 1'b1;
		xfer(1'b1, a2[0], 8'h9f);
		repeat (2) at(4'h0);
		chk("cmp drive", 32'(cmp_bus), 32'(4'he));
		chk("cap 31", {1'b0, cap[30:0]}, 32'h7fff_ffff);
		chk("cap unit1", {1'b0, cap[61:31]}, 32'h0000_0003);
		chk("cap unit3", {1'b0, cap[123:93]}, 32'h0000_000f);
		// phase swap on unit 0
		xfer(1'b1, sca_pkg::IDX_CFG0[0], 8'h40);
		repeat (2) at(4'h0);
		at(4'h3);
		chk("col swap p1", 32'(col[1:0]), 32'(2'b01));
		at(4'h8);
		chk("col swap p2", 32'(col[0]), 32'(1'b1));
		print_verdict();
	end
endmodule : sca_ctrl_test
`default_nettype wire
